// ### hw/dca_pkg.sv
// shared constants for the channel A DDR pin interface
// assumes a controller clock and a separate memory-clock domain
package dca_pkg;

    // ======================================================================
    // pin group widths
    localparam int ROWS       = 4;
    localparam int ADDR_W     = 13;
    localparam int BANK_W     = 2;
    localparam int DATA_W     = 64;
    localparam int STRB_W     = 8;
    localparam int CLK_PAIRS  = 6;    // three pairs for each of two modules
    localparam int DUP_LO     = 1;    // duplicated address slice low bit
    localparam int DUP_HI     = 5;    // duplicated address slice high bit

    // ======================================================================
    // timing counts, in memory-clock cycles
    localparam int INIT_WAIT_CYC = 200;  // cke held low after reset
    localparam int PD_IDLE_CYC   = 16;   // idle cycles before power-down
    localparam int CNT_W         = 16;

    // ======================================================================
    // command codes on the user side
    typedef enum logic [2:0] {
        DCA_CMD_NOP  = 3'h0,
        DCA_CMD_ACT  = 3'h1,
        DCA_CMD_RD   = 3'h2,
        DCA_CMD_WR   = 3'h3,
        DCA_CMD_PRE  = 3'h4,
        DCA_CMD_REF  = 3'h5,
        DCA_CMD_MRS  = 3'h6,
        DCA_CMD_BST  = 3'h7
    } dca_cmd_t;

    // strobe levels {row, column, write} per command, active low
    localparam logic [2:0] STB_NOP = 3'h7;
    localparam logic [2:0] STB_ACT = 3'h3;
    localparam logic [2:0] STB_RD  = 3'h5;
    localparam logic [2:0] STB_WR  = 3'h4;
    localparam logic [2:0] STB_PRE = 3'h2;
    localparam logic [2:0] STB_REF = 3'h1;
    localparam logic [2:0] STB_MRS = 3'h0;
    localparam logic [2:0] STB_BST = 3'h6;

    // link-side sequencer states
    typedef enum logic [2:0] {
        DCA_L_INIT  = 3'h0,
        DCA_L_IDLE  = 3'h1,
        DCA_L_WAKE  = 3'h2,
        DCA_L_WRITE = 3'h3,
        DCA_L_SREF  = 3'h4
    } dca_lstate_t;

endpackage

// ### hw/dca_channel.sv
// channel A DDR pin interface: command issue, data and clock enables
// assumes mem_clk is free running; users sit on mclk, pins on mem_clk
`timescale 1ns/100ps

// Overview of operation
// [R1] complementary clock pairs driven out; memory samples where true rises
// [R2] one active-low chip select per row, updated on memory clock rise
// [R3] row and column share one 13-bit multiplexed address bus
// [R4] duplicate address bits 5:1 always equal primary bits 5:1
// [R5] 2-bit bank address selects bank within addressed row
// [R6] commands encoded by row, column and write strobes with chip select
// [R7] 64-bit data bus driven by us on writes, by memory on reads
// [R8] write strobe edge centred in data; read strobes capture data
// [R9] strobe n qualifies data byte n only
// [R10] one clock enable per row, updated on memory clock rise
// [R11] clock enables held low during power-up initialisation
// [R12] clock enables move rows into and out of self-refresh
// [R13] idle rows powered down; enable restored before access
// [R14] strobe levels follow the standard command truth table
module dca_channel #(
    parameter int INIT_CYC = dca_pkg::INIT_WAIT_CYC,
    parameter int PD_CYC   = dca_pkg::PD_IDLE_CYC
) (
    input  wire logic                          mclk,
    input  wire logic                          rst_n,
    input  wire logic                          mem_clk,
    // user side, mclk domain
    input  wire logic                          cmd_valid,
    output logic                               cmd_ready,
    input  wire logic [2:0]                    cmd_code,
    input  wire logic [1:0]                    cmd_row,
    input  wire logic [dca_pkg::BANK_W-1:0]    cmd_bank,
    input  wire logic [dca_pkg::ADDR_W-1:0]    cmd_addr,
    input  wire logic [dca_pkg::DATA_W-1:0]    cmd_wdata,
    output logic                               rd_valid,
    output logic [dca_pkg::DATA_W-1:0]         rd_data,
    input  wire logic                          suspend_req,
    output logic                               suspend_ack,
    output logic                               init_done,
    // memory pins, mem_clk domain
    output logic [dca_pkg::CLK_PAIRS-1:0]      mem_clock_pair_true,
    output logic [dca_pkg::CLK_PAIRS-1:0]      mem_clock_pair_comp,
    output logic [dca_pkg::ROWS-1:0]           row_select_n,
    output logic [dca_pkg::ROWS-1:0]           row_clock_enable,
    output logic [dca_pkg::ADDR_W-1:0]         mem_addr_primary,
    output logic [dca_pkg::DUP_HI:dca_pkg::DUP_LO] mem_addr_duplicate,
    output logic [dca_pkg::BANK_W-1:0]         bank_addr,
    output logic                               row_strobe_n,
    output logic                               column_strobe_n,
    output logic                               write_enable_n,
    input  wire logic [dca_pkg::DATA_W-1:0]    mem_data_lines_in,
    output logic [dca_pkg::DATA_W-1:0]         mem_data_lines_out,
    output logic [dca_pkg::DATA_W-1:0]         mem_data_lines_oe_n,
    input  wire logic [dca_pkg::STRB_W-1:0]    mem_data_strobe_in,
    output logic [dca_pkg::STRB_W-1:0]         mem_data_strobe_out,
    output logic [dca_pkg::STRB_W-1:0]         mem_data_strobe_oe_n
);
    localparam int DW = dca_pkg::DATA_W;
    localparam int SW = dca_pkg::STRB_W;
    localparam int NR = dca_pkg::ROWS;

    initial
    begin
        if (INIT_CYC < 1 || INIT_CYC >= (1 << dca_pkg::CNT_W) ||
            PD_CYC < 1 || PD_CYC >= (1 << dca_pkg::CNT_W) || DW != 8 * SW)
            $error("dca_channel: unsupported parameter values");
    end

    // strobe levels per command, standard truth table
    function automatic logic [2:0] enc_cmd(input logic [2:0] c);
        case (c)
            dca_pkg::DCA_CMD_ACT: enc_cmd = dca_pkg::STB_ACT;
            dca_pkg::DCA_CMD_RD:  enc_cmd = dca_pkg::STB_RD;
            dca_pkg::DCA_CMD_WR:  enc_cmd = dca_pkg::STB_WR;
            dca_pkg::DCA_CMD_PRE: enc_cmd = dca_pkg::STB_PRE;
            dca_pkg::DCA_CMD_REF: enc_cmd = dca_pkg::STB_REF;
            dca_pkg::DCA_CMD_MRS: enc_cmd = dca_pkg::STB_MRS;
            dca_pkg::DCA_CMD_BST: enc_cmd = dca_pkg::STB_BST;
            default:              enc_cmd = dca_pkg::STB_NOP;
        endcase
    endfunction

    // ======================================================================
    // clock pairs: true follows mem_clk, complement is its inverse
    assign mem_clock_pair_true = {dca_pkg::CLK_PAIRS{mem_clk}};   // [R1]
    assign mem_clock_pair_comp = {dca_pkg::CLK_PAIRS{~mem_clk}};  // [R1]

    // ======================================================================
    // link reset: asserts at once, releases on mem_clk
    logic lrst_s1_q, link_rst_n;
    always_ff @(posedge mem_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lrst_s1_q  <= 1'b0;
            link_rst_n <= 1'b0;
        end
        else
        begin
            lrst_s1_q  <= 1'b1;
            link_rst_n <= lrst_s1_q;
        end
    end

    // ======================================================================
    // mclk side: command hold registers and toggle handshake
    logic            req_tog_q, req_tog_d;
    logic [2:0]      hcode_q, hcode_d;
    logic [1:0]      hrow_q, hrow_d;
    logic [1:0]      hbank_q, hbank_d;
    logic [12:0]     haddr_q, haddr_d;
    logic [DW-1:0]   hwdata_q, hwdata_d;
    logic [2:0]      ack_sy_q, rdt_sy_q, st_sy_q;   // st: init done; sref ack goes through st2 below
    logic [2:0]      st2_sy_q;
    logic            rd_valid_q, rd_valid_d;
    logic [DW-1:0]   rd_data_q, rd_data_d;
    logic            ack_tog_q, rd_tog_q, init_done_q, sref_ack_q;
    logic [DW-1:0]   rd_word_q;
    logic            busy;

    // hold regs stay still while a request is in flight, so the link side
    // may read them once it sees the toggle
    assign busy      = req_tog_q != ack_sy_q[1];
    assign cmd_ready = !busy && st_sy_q[1];
    always_comb
    begin
        req_tog_d  = req_tog_q;
        hcode_d    = hcode_q;
        hrow_d     = hrow_q;
        hbank_d    = hbank_q;
        haddr_d    = haddr_q;
        hwdata_d   = hwdata_q;
        if (cmd_valid && cmd_ready)
        begin
            req_tog_d = ~req_tog_q;
            hcode_d   = cmd_code;
            hrow_d    = cmd_row;
            hbank_d   = cmd_bank;
            haddr_d   = cmd_addr;
            hwdata_d  = cmd_wdata;
        end
        rd_valid_d = rdt_sy_q[1] ^ rdt_sy_q[2];
        rd_data_d  = rd_valid_d ? rd_word_q : rd_data_q;
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            req_tog_q  <= 1'b0;
            hcode_q    <= 3'h0;
            hrow_q     <= 2'h0;
            hbank_q    <= 2'h0;
            haddr_q    <= 13'h0;
            hwdata_q   <= '0;
            ack_sy_q   <= 3'h0;
            rdt_sy_q   <= 3'h0;
            st_sy_q    <= 3'h0;
            st2_sy_q   <= 3'h0;
            rd_valid_q <= 1'b0;
            rd_data_q  <= '0;
        end
        else
        begin
            req_tog_q  <= req_tog_d;
            hcode_q    <= hcode_d;
            hrow_q     <= hrow_d;
            hbank_q    <= hbank_d;
            haddr_q    <= haddr_d;
            hwdata_q   <= hwdata_d;
            ack_sy_q   <= {ack_sy_q[1:0], ack_tog_q};
            rdt_sy_q   <= {rdt_sy_q[1:0], rd_tog_q};
            st_sy_q    <= {st_sy_q[1:0], init_done_q};
            st2_sy_q   <= {st2_sy_q[1:0], sref_ack_q};
            rd_valid_q <= rd_valid_d;
            rd_data_q  <= rd_data_d;
        end
    end
    assign rd_valid    = rd_valid_q;
    assign rd_data     = rd_data_q;
    assign init_done   = st_sy_q[1];
    assign suspend_ack = st2_sy_q[1];

    // ======================================================================
    // link side: sequencer driving the command pins
    dca_pkg::dca_lstate_t st_q, st_d;
    logic [15:0]     cnt_q, cnt_d;
    logic [2:0]      req_sy_q, sref_sy_q;
    logic            ack_tog_d, init_done_d, sref_ack_d;
    logic            rd_pend_q, rd_pend_d, rd_tog_d;
    logic [NR-1:0]   cs_n_q, cs_n_d, cke_q, cke_d;
    logic [12:0]     addr_q, addr_d;
    logic [4:0]      dup_q, dup_d;
    logic [1:0]      ba_q, ba_d;
    logic [2:0]      stb_q, stb_d;
    logic [DW-1:0]   wdat_q, wdat_d, rd_word_d;
    logic            wph_q, wph_d, issue;
    logic [SW-1:0]   got_q, got_d, byte_edge;
    logic [DW-1:0]   cap_q, cap_d, dq_s1_q, dq_s2_q;
    logic [SW-1:0]   dqs_s1_q, dqs_s2_q, dqs_s3_q;
    logic            new_req;

    assign new_req = (req_sy_q[1] != ack_tog_q);

    always_comb
    begin
        st_d        = st_q;
        cnt_d       = cnt_q;
        ack_tog_d   = ack_tog_q;
        init_done_d = init_done_q;
        sref_ack_d  = sref_ack_q;
        rd_pend_d   = rd_pend_q;
        rd_tog_d    = rd_tog_q;
        rd_word_d   = rd_word_q;
        cs_n_d      = {NR{1'b1}};              // deselect unless issuing
        stb_d       = dca_pkg::STB_NOP;
        cke_d       = cke_q;
        addr_d      = addr_q;
        ba_d        = ba_q;
        wdat_d      = wdat_q;
        wph_d       = 1'b0;
        issue       = 1'b0;
        case (st_q)
            dca_pkg::DCA_L_INIT:
            begin
                cke_d = {NR{1'b0}};                            // [R11]
                if (cnt_q == 16'(INIT_CYC - 1))
                begin
                    cke_d       = {NR{1'b1}};                  // [R11]
                    init_done_d = 1'b1;
                    cnt_d       = 16'h0;
                    st_d        = dca_pkg::DCA_L_IDLE;
                end
                else
                    cnt_d = cnt_q + 16'h1;
            end
            dca_pkg::DCA_L_IDLE:
            begin
                if (sref_sy_q[1] && !rd_pend_q)
                begin
                    // refresh with cke falling enters self-refresh
                    cs_n_d     = {NR{1'b0}};                   // [R12]
                    stb_d      = dca_pkg::STB_REF;             // [R12]
                    cke_d      = {NR{1'b0}};                   // [R12]
                    sref_ack_d = 1'b1;
                    st_d       = dca_pkg::DCA_L_SREF;
                end
                else if (new_req && !cke_q[hrow_q])
                begin
                    cke_d[hrow_q] = 1'b1;                      // [R13]
                    st_d          = dca_pkg::DCA_L_WAKE;
                end
                else if (new_req)
                    issue = 1'b1;
                else if (cnt_q == 16'(PD_CYC - 1))
                begin
                    if (!rd_pend_q)
                        cke_d = {NR{1'b0}};                    // [R13]
                end
                else
                    cnt_d = cnt_q + 16'h1;
            end
            dca_pkg::DCA_L_WAKE:
                issue = 1'b1;
            dca_pkg::DCA_L_WRITE:
            begin
                wph_d = 1'b0;
                st_d  = dca_pkg::DCA_L_IDLE;
            end
            dca_pkg::DCA_L_SREF:
            begin
                if (!sref_sy_q[1])
                begin
                    cke_d      = {NR{1'b1}};                   // [R12]
                    sref_ack_d = 1'b0;
                    st_d       = dca_pkg::DCA_L_IDLE;
                end
            end
            default:
                st_d = dca_pkg::DCA_L_INIT;
        endcase
        if (issue)
        begin
            cs_n_d[hrow_q] = 1'b0;                             // [R2] [R6]
            stb_d          = enc_cmd(hcode_q);                 // [R6] [R14]
            addr_d         = haddr_q;                          // [R3]
            ba_d           = hbank_q;                          // [R5]
            ack_tog_d      = ~ack_tog_q;
            cnt_d          = 16'h0;
            st_d           = dca_pkg::DCA_L_IDLE;
            if (hcode_q == dca_pkg::DCA_CMD_WR)
            begin
                wdat_d = hwdata_q;
                wph_d  = 1'b1;                                 // [R7]
                st_d   = dca_pkg::DCA_L_WRITE;
            end
            if (hcode_q == dca_pkg::DCA_CMD_RD)
                rd_pend_d = 1'b1;
        end
        // a read word is complete once every byte saw its own strobe
        got_d = got_q | (rd_pend_q ? byte_edge : {SW{1'b0}});
        if (rd_pend_q && got_d == {SW{1'b1}})
        begin
            rd_word_d = cap_d;
            rd_tog_d  = ~rd_tog_q;
            rd_pend_d = 1'b0;
            got_d     = {SW{1'b0}};
        end
        dup_d = addr_d[dca_pkg::DUP_HI:dca_pkg::DUP_LO];          // [R4]
    end

    always_ff @(posedge mem_clk or negedge link_rst_n)
    begin
        if (!link_rst_n)
        begin
            st_q        <= dca_pkg::DCA_L_INIT;
            cnt_q       <= 16'h0;
            req_sy_q    <= 3'h0;
            sref_sy_q   <= 3'h0;
            ack_tog_q   <= 1'b0;
            init_done_q <= 1'b0;
            sref_ack_q  <= 1'b0;
            rd_pend_q   <= 1'b0;
            rd_tog_q    <= 1'b0;
            rd_word_q   <= '0;
            cs_n_q      <= {NR{1'b1}};
            cke_q       <= {NR{1'b0}};
            addr_q      <= 13'h0;
            dup_q       <= 5'h0;
            ba_q        <= 2'h0;
            stb_q       <= dca_pkg::STB_NOP;
            wdat_q      <= '0;
            wph_q       <= 1'b0;
            got_q       <= '0;
        end
        else
        begin
            st_q        <= st_d;
            cnt_q       <= cnt_d;
            req_sy_q    <= {req_sy_q[1:0], req_tog_q};
            sref_sy_q   <= {sref_sy_q[1:0], suspend_req};
            ack_tog_q   <= ack_tog_d;
            init_done_q <= init_done_d;
            sref_ack_q  <= sref_ack_d;
            rd_pend_q   <= rd_pend_d;
            rd_tog_q    <= rd_tog_d;
            rd_word_q   <= rd_word_d;
            cs_n_q      <= cs_n_d;                             // [R2]
            cke_q       <= cke_d;                              // [R10]
            addr_q      <= addr_d;
            dup_q       <= dup_d;
            ba_q        <= ba_d;
            stb_q       <= stb_d;
            wdat_q      <= wdat_d;
            wph_q       <= wph_d;
            got_q       <= got_d;
        end
    end

    assign row_select_n       = cs_n_q;
    assign row_clock_enable   = cke_q;
    assign mem_addr_primary   = addr_q;
    assign mem_addr_duplicate = dup_q;
    assign bank_addr          = ba_q;
    assign {row_strobe_n, column_strobe_n, write_enable_n} = stb_q;

    // ======================================================================
    // write strobe rises on the falling edge, mid-way through the data
    logic [SW-1:0] dqs_out_q, dqs_out_d;
    always_comb
        dqs_out_d = {SW{wph_q}};                               // [R8]
    always_ff @(negedge mem_clk or negedge link_rst_n)
    begin
        if (!link_rst_n)
            dqs_out_q <= '0;
        else
            dqs_out_q <= dqs_out_d;
    end

    // ======================================================================
    // per-byte data and strobe lanes; read capture on synced strobe edges
    // trades latency for safety: strobes are synchronised, not used as clocks
    genvar g;
    generate
        for (g = 0; g < SW; g++)
        begin : g_lane
            assign mem_data_lines_out[8*g+7:8*g]  = wdat_q[8*g+7:8*g]; // [R9]
            assign mem_data_lines_oe_n[8*g+7:8*g] = {8{~wph_q}};       // [R7]
            assign mem_data_strobe_out[g]         = dqs_out_q[g];      // [R9]
            assign mem_data_strobe_oe_n[g]        = ~wph_q;            // [R8]
            assign byte_edge[g] = dqs_s2_q[g] ^ dqs_s3_q[g];           // [R8]
            assign cap_d[8*g+7:8*g] = byte_edge[g] ?
                dq_s2_q[8*g+7:8*g] : cap_q[8*g+7:8*g];                 // [R9]
        end
    endgenerate

    always_ff @(posedge mem_clk or negedge link_rst_n)
    begin
        if (!link_rst_n)
        begin
            dq_s1_q  <= '0;
            dq_s2_q  <= '0;
            dqs_s1_q <= '0;
            dqs_s2_q <= '0;
            dqs_s3_q <= '0;
            cap_q    <= '0;
        end
        else
        begin
            dq_s1_q  <= mem_data_lines_in;
            dq_s2_q  <= dq_s1_q;
            dqs_s1_q <= mem_data_strobe_in;
            dqs_s2_q <= dqs_s1_q;
            dqs_s3_q <= dqs_s2_q;
            cap_q    <= cap_d;
        end
    end

    // ======================================================================
    // checks, link domain
    sequence s_sref_entry;
        (row_select_n == 4'h0) && (stb_q == dca_pkg::STB_REF) &&
        (row_clock_enable == 4'h0);
    endsequence
    sequence s_write_issue;
        (stb_q == dca_pkg::STB_WR) && (row_select_n != 4'hf);
    endsequence

    a_dup_addr: assert property ( // [R4]
        @(posedge mem_clk) disable iff (!link_rst_n)
        mem_addr_duplicate == mem_addr_primary[5:1])
        else $error("duplicate address differs from primary");
    a_clock_pairs: assert property ( // [R1]
        @(negedge mem_clk) disable iff (!link_rst_n)
        mem_clock_pair_comp == ~mem_clock_pair_true)
        else $error("clock pair not complementary");
    a_one_select: assert property ( // [R2]
        @(posedge mem_clk) disable iff (!link_rst_n)
        (row_select_n != 4'h0) |-> $onehot0(~row_select_n))
        else $error("more than one row selected");
    a_idle_nop: assert property ( // [R6]
        @(posedge mem_clk) disable iff (!link_rst_n)
        (row_select_n == 4'hf) |-> (stb_q == dca_pkg::STB_NOP))
        else $error("strobes active with no row selected");
    a_cke_access: assert property ( // [R13]
        @(posedge mem_clk) disable iff (!link_rst_n)
        (row_select_n != 4'hf && row_select_n != 4'h0) |->
        ((~row_select_n & ~$past(row_clock_enable)) == 4'h0))
        else $error("row accessed with clock enable low");
    a_init_cke: assert property ( // [R11]
        @(posedge mem_clk) disable iff (!link_rst_n)
        (!init_done_q) |-> (row_clock_enable == 4'h0 && row_select_n == 4'hf))
        else $error("clock enable raised during initialisation");
    a_sref_hold: assert property ( // [R12]
        @(posedge mem_clk) disable iff (!link_rst_n)
        s_sref_entry |=> (row_clock_enable == 4'h0) && sref_ack_q)
        else $error("self-refresh not held after entry");
    a_write_drive: assert property ( // [R7]
        @(posedge mem_clk) disable iff (!link_rst_n)
        s_write_issue |-> (mem_data_lines_oe_n == '0) ##1
        (mem_data_lines_oe_n == '1))
        else $error("write data not driven for exactly one cycle");
    a_lane_enable: assert property ( // [R9]
        @(posedge mem_clk) disable iff (!link_rst_n)
        mem_data_strobe_oe_n == {mem_data_lines_oe_n[56],
        mem_data_lines_oe_n[48], mem_data_lines_oe_n[40],
        mem_data_lines_oe_n[32], mem_data_lines_oe_n[24],
        mem_data_lines_oe_n[16], mem_data_lines_oe_n[8],
        mem_data_lines_oe_n[0]})
        else $error("strobe enable differs from its byte");

endmodule

// ### dv/dca_mem_model.sv
// memory rank model standing on the channel A pins
// assumes the bench resolves each pin from the enables
`timescale 1ns/100ps
module dca_mem_model (
    input  wire logic        mem_clk,
    input  wire logic [3:0]  cs_n,
    input  wire logic [2:0]  stb,
    input  wire logic [63:0] dq_out,
    input  wire logic [7:0]  dqs_out,
    input  wire logic [7:0]  dqs_oe_n,
    input  wire logic [63:0] rd_word,
    output logic      [63:0] dq_drv,
    output logic      [7:0]  dqs_drv,
    output logic      [63:0] wr_word
);
    // ==========================================
    int cnt = 0;
    // read burst timer, started by a read on the pins
    always @(posedge mem_clk)
    begin
        if (cnt > 0)
            cnt <= cnt - 1;
        else if (cs_n != 4'hf && stb == 3'h5)
            cnt <= 6;
    end
    // released bus shows the inverse, not a stale word
    assign dq_drv  = (cnt inside {[1:5]}) ? rd_word : ~rd_word;
    assign dqs_drv = {8{cnt == 4}};
    // each byte taken at its own strobe rise
    always @(dqs_out)
    begin
        for (int i = 0; i < 8; i++)
            if (dqs_out[i] && !dqs_oe_n[i])
                wr_word[8*i+:8] = dq_out[8*i+:8];
    end
endmodule

// ### dv/tb.sv
// bench: random commands, data both ways, power states
// assumes dca_pkg, dca_channel and the memory model compiled first
`timescale 1ns/100ps
module tb;
    // ==========================================
    logic        mclk, rst_n, mem_clk, cmd_valid, suspend_req;
    logic        cmd_ready, rd_valid, suspend_ack, init_done;
    logic        row_strobe_n, column_strobe_n, write_enable_n;
    logic [2:0]  cmd_code;
    logic [1:0]  cmd_row, cmd_bank, bank_addr;
    logic [12:0] cmd_addr, mem_addr_primary;
    logic [5:1]  mem_addr_duplicate;
    logic [5:0]  mem_clock_pair_true, mem_clock_pair_comp;
    logic [3:0]  row_select_n, row_clock_enable;
    logic [63:0] cmd_wdata, rd_data, rd_word, wr_word, dq_drv;
    logic [63:0] mem_data_lines_in, mem_data_lines_out, mem_data_lines_oe_n;
    logic [7:0]  mem_data_strobe_in, mem_data_strobe_out;
    logic [7:0]  mem_data_strobe_oe_n, dqs_drv;
    logic [21:0] exp_q[$];
    logic [21:0] pins_now;
    logic [3:0]  sel_rows;
    int          err_total = 0;
    int          tests_run = 0;
    int          seed = 32'h365658bf;
    localparam logic [2:0] stb_tab [8] = '{3'h7, 3'h3, 3'h5, 3'h4,
                                          3'h2, 3'h1, 3'h0, 3'h6};
    // wire level from the channel's enables; the model drives the rest
    assign mem_data_lines_in = (mem_data_lines_oe_n & dq_drv)
                             | (~mem_data_lines_oe_n & mem_data_lines_out);
    assign mem_data_strobe_in = (mem_data_strobe_oe_n & dqs_drv)
                              | (~mem_data_strobe_oe_n & mem_data_strobe_out);
    // command as it stands on the pins, and the rows it selects
    assign pins_now = {row_select_n, row_strobe_n, column_strobe_n,
                       write_enable_n, bank_addr, mem_addr_primary};
    assign sel_rows = ~row_select_n;
    // short counts keep the run brief
    dca_channel #(.INIT_CYC(4), .PD_CYC(4)) dut (.mclk, .rst_n, .mem_clk,
        .cmd_valid, .cmd_ready, .cmd_code, .cmd_row, .cmd_bank, .cmd_addr,
        .cmd_wdata, .rd_valid, .rd_data, .suspend_req, .suspend_ack,
        .init_done, .mem_clock_pair_true, .mem_clock_pair_comp,
        .row_select_n, .row_clock_enable, .mem_addr_primary,
        .mem_addr_duplicate, .bank_addr, .row_strobe_n, .column_strobe_n,
        .write_enable_n, .mem_data_lines_in, .mem_data_lines_out,
        .mem_data_lines_oe_n, .mem_data_strobe_in, .mem_data_strobe_out,
        .mem_data_strobe_oe_n);
    dca_mem_model mem (.mem_clk, .cs_n(row_select_n),
        .stb({row_strobe_n, column_strobe_n, write_enable_n}),
        .dq_out(mem_data_lines_out), .dqs_out(mem_data_strobe_out),
        .dqs_oe_n(mem_data_strobe_oe_n), .rd_word, .dq_drv, .dqs_drv,
        .wr_word);
    // clocks; link offset so the phases never line up
    initial
    begin
        mclk = 0;
        forever #5 mclk = ~mclk;
    end
    initial
    begin
        mem_clk = 0;
        #7;
        forever #15 mem_clk = ~mem_clk;
    end
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic final_report;
        if (err_total == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // bounded wait: 0 ready, 1 read valid, 2 suspend ack, 3 init done
    task automatic wait_sig(input int sel, input logic lvl);
        int         n;
        logic [3:0] s;
        for (n = 0; n < 3000; n++)
        begin
            @(posedge mclk);
            #1;
            s = {init_done, suspend_ack, rd_valid, cmd_ready};
            if (s[sel] === lvl)
                break;
        end
        if (n == 3000)
        begin
            err_total++;
            final_report;
        end
    endtask
    task automatic issue(input logic [2:0] c, input logic [1:0] r);
        wait_sig(0, 1);
        cmd_code = c;
        cmd_row = r;
        cmd_bank = 2'($random(seed));
        cmd_addr = 13'($random(seed));
        cmd_wdata = {$random(seed), $random(seed)};
        cmd_valid = 1;
        exp_q.push_back({~(4'h1 << r), stb_tab[c], cmd_bank, cmd_addr});
        @(posedge mclk);
        #1;
        cmd_valid = 0;
    endtask
    // pin monitor: every single-row command against the expected queue
    always @(posedge mem_clk)
    begin
        #1;
        chk(mem_addr_duplicate, mem_addr_primary[5:1]);
        chk(mem_clock_pair_comp ^ mem_clock_pair_true, 6'h3f);
        if (row_select_n != 4'hf && row_select_n != 4'h0)
        begin
            chk(pins_now, exp_q.pop_front());
            chk(row_clock_enable & sel_rows, sel_rows);
        end
        if (row_select_n == 4'h0)
            chk(row_clock_enable, 4'h0);
    end
    initial
    begin
        logic [2:0] c;
        {rst_n, cmd_valid, suspend_req, cmd_code, cmd_row} = 0;
        {cmd_bank, cmd_addr, cmd_wdata, rd_word} = 0;
        repeat (8) @(posedge mclk);
        #1;
        rst_n = 1;
        repeat (3) @(posedge mclk);
        chk(row_clock_enable, 4'h0);
        wait_sig(3, 1);
        chk(row_clock_enable, 4'hf);
        // every code twice, no-operation included
        for (int k = 0; k < 16; k++)
        begin
            c = 3'(k % 8);
            rd_word = {$random(seed), $random(seed)};
            issue(c, 2'($random(seed)));
            if (c == 3'h2)
                wait_sig(1, 1);
            if (c == 3'h2)
                chk(rd_data, rd_word);
            if (c == 3'h3)
            begin
                wait_sig(0, 1);
                // ready may return before the mid-cycle strobe lands
                repeat (2) @(posedge mclk);
                chk(wr_word, cmd_wdata);
            end
        end
        // idle long enough for power-down, then wake one row
        repeat (40) @(posedge mclk);
        chk(row_clock_enable, 4'h0);
        issue(3'h1, 2'h2);
        wait_sig(0, 1);
        suspend_req = 1;
        wait_sig(2, 1);
        chk(row_clock_enable, 4'h0);
        suspend_req = 0;
        wait_sig(2, 0);
        chk(row_clock_enable, 4'hf);
        chk(exp_q.size(), 0);
        final_report;
    end
endmodule
